// >>> design/ufir_cfg.svh
// ufir: register offsets, field positions, reset values and timing counts
`ifndef UFIR_CFG_SVH
`define UFIR_CFG_SVH

// ************************************
// register byte offsets
// ************************************
`define UFIR_A_DATA   8'h00
`define UFIR_A_IER    8'h04
`define UFIR_A_IIR    8'h08
`define UFIR_A_LCR    8'h0c
`define UFIR_A_LSR    8'h10
`define UFIR_A_DIV    8'h14
`define UFIR_A_IRC    8'h18

// ************************************
// field positions
// ************************************
`define UFIR_IER_RX    0
`define UFIR_IER_TX    1
`define UFIR_IER_LS    2
`define UFIR_FCR_EN    0
`define UFIR_FCR_RXRST 1
`define UFIR_FCR_TXRST 2
`define UFIR_FCR_TRIG  6
`define UFIR_IRC_PINS  0
`define UFIR_IRC_MODE  1
`define UFIR_IRC_HDEN  3
`define UFIR_IRC_STEPS 4
`define UFIR_IRC_MSEL  11
`define UFIR_IRC_R3SEL 12
`define UFIR_IRC_DDVAL 13
`define UFIR_IRC_TMVAL 14
`define UFIR_IRC_THIRD 15

// ************************************
// reset values
// ************************************
`define UFIR_LCR_RST  8'h03
`define UFIR_DIV_RST  16'h0001

// ************************************
// sizes and timing
// ************************************
`define UFIR_DEPTH     5'd16
`define UFIR_TO_CHARS  7'd4
`define UFIR_HD_MAX    7'd100
`define UFIR_CLK_NS    5
`define UFIR_CAR_NS    2000
`define UFIR_HD_STEP_NS 100000
`define UFIR_CAR_HALF  (`UFIR_CAR_NS / 2 / `UFIR_CLK_NS)

`endif

// >>> design/ufir_pkg.sv
// ufir: shared types
package ufir_pkg;
	typedef enum logic [1:0] {UFIR_UART, UFIR_PULSE, UFIR_ASK} ufir_ir_mode_e;
	typedef enum logic {UFIR_RX_IDLE, UFIR_RX_BITS} ufir_rx_st_e;
	typedef enum logic {UFIR_DIR_TX, UFIR_DIR_RX} ufir_dir_e;
endpackage

// >>> design/ufir_top.sv
// ufir: fifo uart with infrared encoding and ahb-lite register slave
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "ufir_cfg.svh"

module ufir_top import ufir_pkg::*; #(
	parameter int unsigned HD_STEP_CYC = `UFIR_HD_STEP_NS / `UFIR_CLK_NS
) (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rstn_in,
	// ahb-lite slave
	input  wire logic        hsel_in,
	input  wire logic [7:0]  haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// serial and infrared pins
	input  wire logic        second_port_serial_in,
	input  wire logic        infrared_receive_pin_in,
	output logic             second_port_serial_out,
	output logic             infrared_transmit_pin_out,
	// drive density pin, two-way
	input  wire logic        drive_density_pin_in,
	output logic             drive_density_pin_out,
	output logic             drive_density_pin_oe_out,
	// interrupt
	output logic             irq_out
);

	// ************************************
	// declarations
	// ************************************
	logic        acc_q, acc_wr_q;
	logic [7:0]  acc_a_q;
	logic        wr, rd, accept;
	logic [2:0]  ier_q;
	logic [7:0]  lcr_q;
	logic [15:0] div_q, div_eff, base_q, pw, hold_len, hold_q;
	logic        fen_q;
	logic [1:0]  trig_q;
	logic        ir_pins_q, hd_en_q, msel_q, r3sel_q, dd_val_q, tm_val_q;
	ufir_ir_mode_e mode_q;
	logic [6:0]  hd_steps_q;
	logic [2:0]  s1_q, s2_q;
	logic        tick;
	logic [3:0]  char_bits, nd;
	logic [4:0]  cap;
	logic [7:0]  txf [16];
	logic [7:0]  rxf [16];
	logic [3:0]  tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
	logic [4:0]  tx_cnt_q, rx_cnt_q;
	logic        tx_push, tx_pop, tx_rst, rx_push, rx_pop, rx_rst, rx_done;
	logic [11:0] tx_sr_q, tx_fr;
	logic [3:0]  tx_left_q;
	logic [7:0]  tx_d;
	logic        tx_busy, tx_line, tx_done, tx_allow, enc;
	logic        arm_q, oe_q;
	logic [5:0]  dly_q;
	logic [6:0]  to_cnt_q;
	logic        to_flag, rx_trig_hit, thre_irq;
	logic [4:0]  trig_lvl;
	logic [2:0]  iid;
	logic        raw_rx, rx_line, rx_in, rx_block;
	ufir_rx_st_e rx_st_q;
	logic [15:0] rx_sub_q;
	logic [3:0]  rx_n_q;
	logic [7:0]  rx_sh_q;
	logic [8:0]  car_cnt_q;
	logic        car_q;
	logic        hd_run_q;
	ufir_dir_e   hd_dir_q;
	logic [6:0]  hd_step_q;
	logic [31:0] hd_sub_q;
	logic        third_q;
	logic [31:0] rdata;

	// ************************************
	// ahb-lite slave, one wait state
	// ************************************
	assign accept = hsel_in && htrans_in[1] && hready_in;
	assign wr = acc_q && acc_wr_q;
	assign rd = acc_q && !acc_wr_q;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			acc_q <= 1'b0;
			acc_wr_q <= 1'b0;
			acc_a_q <= 8'h00;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			hrdata_out <= 32'h0000_0000;
		end else begin
			acc_q <= accept;
			hreadyout_out <= !accept;
			hresp_out <= 1'b0;
			if (accept) begin
				acc_wr_q <= hwrite_in;
				acc_a_q <= haddr_in;
			end
			if (rd) begin
				hrdata_out <= rdata;
			end
		end
	end

	// fifo bits read zero when disabled
	always_comb begin
		rdata = 32'h0000_0000;
		unique case (acc_a_q)
			`UFIR_A_DATA: rdata = {24'h0, rxf[rx_rp_q]};
			`UFIR_A_IER:  rdata = {29'h0, ier_q};
			`UFIR_A_IIR:  rdata = {24'h0, {2{fen_q}}, 2'b00, iid, !irq_out};
			`UFIR_A_LCR:  rdata = {24'h0, lcr_q};
			`UFIR_A_LSR:  rdata = {25'h0, tx_cnt_q == 5'd0 && !tx_busy,
				tx_cnt_q == 5'd0, 3'b000, oe_q, rx_cnt_q != 5'd0};
			`UFIR_A_DIV:  rdata = {16'h0, div_q};
			`UFIR_A_IRC:  rdata = {16'h0, third_q, tm_val_q, dd_val_q, r3sel_q,
				msel_q, hd_steps_q, hd_en_q, mode_q, ir_pins_q};
			default:      rdata = 32'h0000_0000;
		endcase
	end

	// ************************************
	// control registers
	// ************************************
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ier_q <= 3'b000;
			lcr_q <= `UFIR_LCR_RST;
			div_q <= `UFIR_DIV_RST;
			fen_q <= 1'b0;
			trig_q <= 2'b00;
		end else if (wr) begin
			if (acc_a_q == `UFIR_A_IER) ier_q <= hwdata_in[2:0];
			if (acc_a_q == `UFIR_A_LCR) lcr_q <= hwdata_in[7:0];
			if (acc_a_q == `UFIR_A_DIV) div_q <= hwdata_in[15:0];
			if (acc_a_q == `UFIR_A_IIR) begin
				fen_q <= hwdata_in[`UFIR_FCR_EN];
				trig_q <= hwdata_in[`UFIR_FCR_TRIG +: 2];
			end
		end
	end

	// reset returns pin to drive density
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ir_pins_q <= 1'b0;
			mode_q <= UFIR_UART;
			hd_en_q <= 1'b0;
			hd_steps_q <= 7'd0;
			msel_q <= 1'b0;
			r3sel_q <= 1'b0;
			dd_val_q <= 1'b0;
			tm_val_q <= 1'b0;
		end else if (wr && acc_a_q == `UFIR_A_IRC) begin
			ir_pins_q <= hwdata_in[`UFIR_IRC_PINS];
			// unused mode code falls back to plain serial
			mode_q <= (hwdata_in[`UFIR_IRC_MODE +: 2] == 2'b11) ? UFIR_UART :
				ufir_ir_mode_e'(hwdata_in[`UFIR_IRC_MODE +: 2]);
			hd_en_q <= hwdata_in[`UFIR_IRC_HDEN];
			// steps clamp at the 10 ms ceiling
			hd_steps_q <= (hwdata_in[`UFIR_IRC_STEPS +: 7] > `UFIR_HD_MAX) ?
				`UFIR_HD_MAX : hwdata_in[`UFIR_IRC_STEPS +: 7];
			msel_q <= hwdata_in[`UFIR_IRC_MSEL];
			r3sel_q <= hwdata_in[`UFIR_IRC_R3SEL];
			dd_val_q <= hwdata_in[`UFIR_IRC_DDVAL];
			tm_val_q <= hwdata_in[`UFIR_IRC_TMVAL];
		end
	end

	// ************************************
	// pin synchronisers and baud tick
	// ************************************
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s1_q <= 3'b001;
			s2_q <= 3'b001;
		end else begin
			s1_q <= {drive_density_pin_in, infrared_receive_pin_in, second_port_serial_in};
			s2_q <= s1_q;
		end
	end

	// divisor zero behaves as one
	assign div_eff = (div_q == 16'h0) ? 16'h0001 : div_q;
	assign tick = (base_q >= div_eff - 16'h0001);

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) base_q <= 16'h0000;
		else base_q <= tick ? 16'h0000 : base_q + 16'h0001;
	end

	// bits per char from line format
	assign nd = 4'd5 + {2'b00, lcr_q[1:0]};
	assign char_bits = 4'd7 + {2'b00, lcr_q[1:0]} + {3'b000, lcr_q[3]} + {3'b000, lcr_q[2]};
	assign cap = fen_q ? `UFIR_DEPTH : 5'd1;

	// ************************************
	// transmit fifo
	// ************************************
	assign tx_rst = wr && acc_a_q == `UFIR_A_IIR && hwdata_in[`UFIR_FCR_TXRST];
	// no load while holding a full fifo
	assign tx_push = wr && acc_a_q == `UFIR_A_DATA && tx_cnt_q < cap;
	// idle shifter takes next byte itself
	assign tx_pop = tick && !tx_busy && tx_cnt_q != 5'd0 && tx_allow;

	always_ff @(posedge sys_clk_in) begin
		if (tx_push) txf[tx_wp_q] <= hwdata_in[7:0];
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_wp_q <= 4'h0;
			tx_rp_q <= 4'h0;
			tx_cnt_q <= 5'd0;
		end else if (tx_rst) begin
			tx_wp_q <= 4'h0;
			tx_rp_q <= 4'h0;
			tx_cnt_q <= 5'd0;
		end else begin
			if (tx_push) tx_wp_q <= tx_wp_q + 4'h1;
			if (tx_pop) tx_rp_q <= tx_rp_q + 4'h1;
			tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
		end
	end

	// ************************************
	// transmit shifter
	// ************************************
	assign tx_d = txf[tx_rp_q] & 8'(8'hff >> (2'd3 - lcr_q[1:0]));

	always_comb begin
		tx_fr = (12'hfff << (nd + 4'd1)) | {3'b000, tx_d, 1'b0};
		if (lcr_q[3]) tx_fr[nd + 4'd1] = lcr_q[5] ? !lcr_q[4] : (^tx_d ^ !lcr_q[4]);
	end

	assign tx_busy = tx_left_q != 4'd0;
	assign tx_done = tick && tx_left_q == 4'd1;
	assign tx_line = lcr_q[6] ? 1'b0 : (tx_busy ? tx_sr_q[0] : 1'b1);

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_sr_q <= 12'hfff;
			tx_left_q <= 4'd0;
		end else if (tx_pop) begin
			tx_sr_q <= tx_fr;
			tx_left_q <= char_bits;
		end else if (tick && tx_busy) begin
			tx_sr_q <= {1'b1, tx_sr_q[11:1]};
			tx_left_q <= tx_left_q - 4'd1;
		end
	end

	// ************************************
	// transmit-empty interrupt pacing
	// ************************************
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			arm_q <= 1'b1;
			dly_q <= 6'd0;
		end else begin
			// first byte into empty fifo waits a char
			if (tx_push && tx_cnt_q == 5'd0 && arm_q) dly_q <= {2'b00, char_bits};
			else if (tick && dly_q != 6'd0) dly_q <= dly_q - 6'd1;
			// two bytes together drop the delay
			if (tx_cnt_q >= 5'd2) arm_q <= 1'b0;
			else if (tx_cnt_q == 5'd0 && dly_q == 6'd0) arm_q <= 1'b1;
		end
	end

	// empty and enabled, outside the delay
	// a load masks it before the count turns nonzero
	assign thre_irq = ier_q[`UFIR_IER_TX] && tx_cnt_q == 5'd0 && dly_q == 6'd0 && !tx_push;

	// ************************************
	// infrared encoding and pin selection
	// ************************************
	assign pw = ((div_eff >> 3) + (div_eff >> 4) == 16'h0) ? 16'h0001 :
		(div_eff >> 3) + (div_eff >> 4);

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			car_cnt_q <= 9'd0;
			car_q <= 1'b0;
		end else if (car_cnt_q == 9'(`UFIR_CAR_HALF - 1)) begin
			car_cnt_q <= 9'd0;
			car_q <= !car_q;
		end else begin
			car_cnt_q <= car_cnt_q + 9'd1;
		end
	end

	always_comb begin
		unique case (mode_q)
			// short pulse at the head of a zero bit
			UFIR_PULSE: enc = !tx_line && base_q < pw;
			// carrier for the whole zero bit
			UFIR_ASK:   enc = !tx_line && car_q;
			default:    enc = tx_line;
		endcase
	end

	// infrared on the chosen pin pair
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			second_port_serial_out <= 1'b1;
			infrared_transmit_pin_out <= 1'b0;
		end else begin
			second_port_serial_out <= (mode_q == UFIR_UART || !ir_pins_q) ? enc : 1'b1;
			infrared_transmit_pin_out <= (mode_q != UFIR_UART && ir_pins_q) ? enc : 1'b0;
		end
	end

	// ************************************
	// receive decode and blocking
	// ************************************
	assign raw_rx = (mode_q != UFIR_UART && ir_pins_q) ? s2_q[1] : s2_q[0];
	// a pulse or carrier burst stretches to a low bit
	assign hold_len = (mode_q == UFIR_PULSE) ? div_eff : 16'(2 * `UFIR_CAR_HALF);

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) hold_q <= 16'h0000;
		// plain mode keeps no hold, so a mode switch starts no false frame
		else if (mode_q == UFIR_UART) hold_q <= 16'h0000;
		else if (raw_rx) hold_q <= hold_len;
		else if (hold_q != 16'h0000) hold_q <= hold_q - 16'h0001;
	end

	assign rx_line = (mode_q == UFIR_UART) ? raw_rx : (hold_q == 16'h0000);
	// receiver deaf while sending or after
	assign rx_block = hd_en_q && (tx_busy || (hd_run_q && hd_dir_q == UFIR_DIR_TX));
	assign rx_in = rx_block ? 1'b1 : rx_line;
	assign tx_allow = !hd_en_q ||
		!(rx_st_q == UFIR_RX_BITS || (hd_run_q && hd_dir_q == UFIR_DIR_RX));

	// ************************************
	// receive shifter
	// ************************************
	assign rx_done = rx_st_q == UFIR_RX_BITS && rx_sub_q == 16'h0000 &&
		rx_n_q == char_bits - 4'd1 - {3'b000, lcr_q[2]};

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_st_q <= UFIR_RX_IDLE;
			rx_sub_q <= 16'h0000;
			rx_n_q <= 4'd0;
			rx_sh_q <= 8'h00;
		end else begin
			unique case (rx_st_q)
				UFIR_RX_IDLE: begin
					if (!rx_in) begin
						rx_st_q <= UFIR_RX_BITS;
						rx_sub_q <= div_eff >> 1;
						rx_n_q <= 4'd0;
					end
				end
				UFIR_RX_BITS: begin
					if (rx_sub_q != 16'h0000) begin
						rx_sub_q <= rx_sub_q - 16'h0001;
					end else begin
						rx_sub_q <= div_eff - 16'h0001;
						rx_n_q <= rx_n_q + 4'd1;
						if (rx_n_q >= 4'd1 && rx_n_q <= nd) rx_sh_q <= {rx_in, rx_sh_q[7:1]};
						// false start or first stop bit ends the frame
						if ((rx_n_q == 4'd0 && rx_in) || rx_done) rx_st_q <= UFIR_RX_IDLE;
					end
				end
			endcase
		end
	end

	// ************************************
	// receive fifo, overrun, timeout
	// ************************************
	assign rx_rst = wr && acc_a_q == `UFIR_A_IIR && hwdata_in[`UFIR_FCR_RXRST];
	// capacity 16 with fifo enabled, else 1, trigger aside
	assign rx_push = rx_done && rx_cnt_q < cap;
	assign rx_pop = rd && acc_a_q == `UFIR_A_DATA && rx_cnt_q != 5'd0;

	always_ff @(posedge sys_clk_in) begin
		if (rx_push) rxf[rx_wp_q] <= 8'(rx_sh_q >> (4'd8 - nd));
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_wp_q <= 4'h0;
			rx_rp_q <= 4'h0;
			rx_cnt_q <= 5'd0;
		end else if (rx_rst) begin
			rx_wp_q <= 4'h0;
			rx_rp_q <= 4'h0;
			rx_cnt_q <= 5'd0;
		end else begin
			if (rx_push) rx_wp_q <= rx_wp_q + 4'h1;
			if (rx_pop) rx_rp_q <= rx_rp_q + 4'h1;
			rx_cnt_q <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
		end
	end

	// char into a full fifo flags overrun
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) oe_q <= 1'b0;
		else if (rx_done && !rx_push) oe_q <= 1'b1;
		else if (rd && acc_a_q == `UFIR_A_LSR) oe_q <= 1'b0;
	end

	// any push or pop restarts the idle count
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) to_cnt_q <= 7'd0;
		else if (rx_push || rx_pop || rx_rst) to_cnt_q <= 7'd0;
		else if (tick && rx_cnt_q != 5'd0 && !to_flag) to_cnt_q <= to_cnt_q + 7'd1;
	end

	// four char times of quiet with data held
	assign to_flag = fen_q && rx_cnt_q != 5'd0 && to_cnt_q >= 7'(`UFIR_TO_CHARS * char_bits);

	always_comb begin
		unique case (trig_q)
			2'd0: trig_lvl = 5'd1;
			2'd1: trig_lvl = 5'd4;
			2'd2: trig_lvl = 5'd8;
			2'd3: trig_lvl = 5'd14;
		endcase
	end

	// count at trigger with fifo enabled, else at one
	assign rx_trig_hit = rx_cnt_q >= (fen_q ? trig_lvl : 5'd1);

	// ************************************
	// interrupt identification
	// ************************************
	always_comb begin
		if (ier_q[`UFIR_IER_LS] && oe_q) iid = 3'b011;
		else if (ier_q[`UFIR_IER_RX] && rx_trig_hit) iid = 3'b010;
		else if (ier_q[`UFIR_IER_RX] && to_flag) iid = 3'b110;
		else if (thre_irq) iid = 3'b001;
		else iid = 3'b000;
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) irq_out <= 1'b0;
		else irq_out <= iid != 3'b000;
	end

	// ************************************
	// half-duplex turnaround timer
	// ************************************
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hd_run_q <= 1'b0;
			hd_dir_q <= UFIR_DIR_TX;
			hd_step_q <= 7'd0;
			hd_sub_q <= 32'd0;
		end else if (hd_en_q && (tx_done || rx_done)) begin
			// restart at end of each sent byte
			// restart at end of each received char
			hd_run_q <= hd_steps_q != 7'd0;
			hd_dir_q <= tx_done ? UFIR_DIR_TX : UFIR_DIR_RX;
			hd_step_q <= hd_steps_q;
			hd_sub_q <= 32'd0;
		end else if (hd_run_q) begin
			if (hd_sub_q == HD_STEP_CYC - 1) begin
				hd_sub_q <= 32'd0;
				hd_step_q <= hd_step_q - 7'd1;
				if (hd_step_q == 7'd1) hd_run_q <= 1'b0;
			end else begin
				hd_sub_q <= hd_sub_q + 32'd1;
			end
		end
	end

	// ************************************
	// drive density pin mux
	// ************************************
	// pin role from mode and third-input selects
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			drive_density_pin_out <= 1'b0;
			drive_density_pin_oe_out <= 1'b1;
			third_q <= 1'b0;
		end else begin
			drive_density_pin_out <= msel_q ? tm_val_q : dd_val_q;
			drive_density_pin_oe_out <= !(msel_q && r3sel_q);
			third_q <= (msel_q && r3sel_q) ? s2_q[2] : 1'b0;
		end
	end

endmodule // ufir_top

// >>> verification/ufir_assertions.sv
// ufir: port assertions for the register slave and pins
`timescale 1ns/1ps
module ufir_assertions (
	// clock and reset
	input wire logic        sys_clk_in,
	input wire logic        rstn_in,
	// bus
	input wire logic        hsel_in,
	input wire logic [7:0]  haddr_in,
	input wire logic [1:0]  htrans_in,
	input wire logic        hwrite_in,
	input wire logic        hready_in,
	input wire logic [31:0] hrdata_out,
	input wire logic        hreadyout_out,
	input wire logic        hresp_out,
	// pins
	input wire logic        second_port_serial_out,
	input wire logic        infrared_transmit_pin_out,
	input wire logic        drive_density_pin_out,
	input wire logic        drive_density_pin_oe_out,
	input wire logic        irq_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	logic acc;
	logic irc_seen_q;
	assign acc = hsel_in && htrans_in[1] && hready_in;
	// set at the address edge, so it leads the write itself
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			irc_seen_q <= 1'b0;
		else if (acc && hwrite_in && haddr_in == 8'h18)
			irc_seen_q <= 1'b1;
	end
	property p_okay; hresp_out == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("error response");
	property p_wait; acc |=> !hreadyout_out ##1 hreadyout_out; endproperty
	a_wait: assert property (p_wait) else $error("wrong wait states");
	property p_fall; $fell(hreadyout_out) |-> $past(acc); endproperty
	a_fall: assert property (p_fall) else $error("stray wait state");
	property p_rhold; $changed(hrdata_out) |-> $rose(hreadyout_out); endproperty
	a_rhold: assert property (p_rhold) else $error("read data moved");
	property p_upper; hrdata_out[31:16] == 16'h0000; endproperty
	a_upper: assert property (p_upper) else $error("upper bits set");
	property p_rst;
		$rose(rstn_in) |-> second_port_serial_out && !infrared_transmit_pin_out && !irq_out;
	endproperty
	a_rst: assert property (p_rst) else $error("pins not reset");
	property p_dd; !irc_seen_q |-> drive_density_pin_oe_out && !drive_density_pin_out; endproperty
	a_dd: assert property (p_dd) else $error("density pin not default");
	property p_irpin; !irc_seen_q |-> !infrared_transmit_pin_out; endproperty
	a_irpin: assert property (p_irpin) else $error("infrared pin active");
	c_read: cover property (acc && !hwrite_in);
	c_ir: cover property ($rose(infrared_transmit_pin_out));
	c_irq: cover property ($rose(irq_out));
endmodule // ufir_assertions

bind ufir_top ufir_assertions i_ufir_assertions (.sys_clk_in, .rstn_in, .hsel_in, .haddr_in,
	.htrans_in, .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
	.second_port_serial_out, .infrared_transmit_pin_out, .drive_density_pin_out,
	.drive_density_pin_oe_out, .irq_out);

// >>> verification/ufir_line_model.sv
// ufir: serial line partner, plain 8n1 frames
`timescale 1ns/1ps
module ufir_line_model (
	// clock and bit length
	input wire logic        clk_in,
	input wire logic [15:0] div_in,
	// line
	input wire logic        line_in,
	output logic            line_out,
	// decoded bytes
	output logic [7:0]      rx_byte_out,
	output int              rx_count_out
);
	initial begin
		line_out = 1'b1;
		rx_count_out = 0;
		rx_byte_out = 8'h00;
	end
	// mid-bit sampling tolerates the device's input synchroniser
	always begin
		@(negedge line_in);
		repeat (div_in / 2) @(posedge clk_in);
		for (int i = 0; i < 8; i++) begin
			repeat (div_in) @(posedge clk_in);
			rx_byte_out[i] = line_in;
		end
		repeat (div_in) @(posedge clk_in);
		rx_count_out = rx_count_out + 1;
	end
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int k = 0; k < 10; k++) begin
			@(posedge clk_in);
			line_out <= f[k];
			repeat (div_in - 1) @(posedge clk_in);
		end
	endtask
endmodule // ufir_line_model

// >>> verification/ufir_top_tb.sv
// ufir: self-checking bench for the fifo uart with infrared pins
`timescale 1ns/1ps
module ufir_top_tb;
	logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, dd_ext = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rdv;
	logic        hready, sout, infrared_transmit_pin, ddout, ddoe, irq, line, dd_pin;
	logic [7:0]  mb;
	int          mc;
	int          err_count = 0;
	int          total_checks = 0;
	always #2.5 clk = ~clk;
	// pad level: device drives while enabled, else the bench
	assign dd_pin = ddoe ? ddout : dd_ext;
	// infrared output looped back into the infrared receiver
	ufir_top #(.HD_STEP_CYC(20)) i_ufir_top (
		.sys_clk_in(clk), .rstn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
		.second_port_serial_in(line), .infrared_receive_pin_in(infrared_transmit_pin),
		.second_port_serial_out(sout), .infrared_transmit_pin_out(infrared_transmit_pin),
		.drive_density_pin_in(dd_pin), .drive_density_pin_out(ddout),
		.drive_density_pin_oe_out(ddoe), .irq_out(irq));
	ufir_line_model i_ufir_line_model (.clk_in(clk), .div_in(16'h0040), .line_in(sout),
		.line_out(line), .rx_byte_out(mb), .rx_count_out(mc));
	// ****
	// helpers
	// ****
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			end_of_test;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		wrdy;
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		wrdy;
		rdv = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdv, e);
	endtask
	task automatic wirq(input logic v, input int lim, output int n);
		n = 0;
		while (irq !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(32'(irq), 32'(v));
		if (n >= lim)
			end_of_test;
	endtask
	task automatic wmc(input int t);
		int n;
		n = 0;
		while (mc < t && n < 20000) begin
			@(posedge clk);
			n++;
		end
		chk(32'(n < 20000), 32'h1);
		if (n >= 20000)
			end_of_test;
	endtask
	task automatic rst;
		rstn <= 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
	endtask
	// counts infrared pulses and longest high run; serial pin must stay idle
	task automatic watch(input int cyc, output int r, output int hmax);
		int run;
		r = 0;
		hmax = 0;
		run = 0;
		repeat (cyc) begin
			@(posedge clk);
			run = infrared_transmit_pin ? run + 1 : 0;
			if (run == 1)
				r++;
			if (run > hmax)
				hmax = run;
			if (sout !== 1'b1)
				r = r + 100;
		end
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_reset;
		logic [7:0] a[8] = '{8'h0c, 8'h14, 8'h04, 8'h08, 8'h10, 8'h18, 8'h1c, 8'h40};
		logic [31:0] e[8] = '{32'h3, 32'h1, 32'h0, 32'h1, 32'h60, 32'h0, 32'h0, 32'h0};
		bus(1'b1, 8'h1c, 32'hffffffff);
		for (int i = 0; i < 8; i++)
			rchk(a[i], e[i]);
	endtask
	task automatic t_tx;
		int n;
		int c0;
		bus(1'b1, 8'h14, 32'h40);
		bus(1'b1, 8'h08, 32'h1);
		bus(1'b1, 8'h04, 32'h2);
		wirq(1'b1, 20, n);
		c0 = mc;
		bus(1'b1, 8'h00, 32'ha5);
		wirq(1'b0, 4, n);
		repeat (500) @(posedge clk);
		chk(32'(irq), 32'h0);
		wmc(c0 + 1);
		chk(32'(mb), 32'ha5);
		wirq(1'b1, 200, n);
		rchk(8'h08, 32'hc2);
	endtask
	task automatic t_burst;
		int n;
		int c0;
		int c1;
		c0 = mc;
		for (int i = 0; i < 20; i++)
			bus(1'b1, 8'h00, 32'h10 + i);
		wirq(1'b1, 15000, n);
		c1 = mc - c0;
		repeat (1400) @(posedge clk);
		n = mc - c0;
		chk(n - c1, 1);
		chk(32'(n == 16 || n == 17), 32'h1);
		chk(32'(mb), 32'h10 + n - 1);
	endtask
	task automatic t_rx;
		int n;
		bus(1'b1, 8'h04, 32'h5);
		bus(1'b1, 8'h08, 32'hc1);
		for (int i = 0; i < 13; i++)
			i_ufir_line_model.send(8'(8'h40 + i));
		repeat (100) @(posedge clk);
		chk(32'(irq), 32'h0);
		i_ufir_line_model.send(8'h4d);
		wirq(1'b1, 300, n);
		rchk(8'h08, 32'hc4);
		for (int i = 14; i < 17; i++)
			i_ufir_line_model.send(8'(8'h40 + i));
		repeat (100) @(posedge clk);
		rchk(8'h10, 32'h63);
		for (int i = 0; i < 16; i++)
			rchk(8'h00, 32'h40 + i);
		rchk(8'h10, 32'h60);
	endtask
	task automatic t_tmo;
		int n;
		i_ufir_line_model.send(8'h5a);
		wirq(1'b1, 3000, n);
		chk(32'(n > 2200), 32'h1);
		rchk(8'h08, 32'hcc);
		rchk(8'h00, 32'h5a);
		wirq(1'b0, 4, n);
	endtask
	task automatic t_ir;
		int r;
		int h;
		bus(1'b1, 8'h04, 32'h0);
		bus(1'b1, 8'h18, 32'h3);
		bus(1'b1, 8'h00, 32'h0);
		watch(900, r, h);
		chk(r, 9);
		rchk(8'h10, 32'h61);
		rchk(8'h00, 32'h0);
		bus(1'b1, 8'h14, 32'h3e8);
		bus(1'b1, 8'h18, 32'h5);
		bus(1'b1, 8'h00, 32'hff);
		watch(12000, r, h);
		chk(h, 200);
		chk(32'(r < 100), 32'h1);
		bus(1'b1, 8'h18, 32'h0);
		bus(1'b1, 8'h14, 32'h40);
	endtask
	// half duplex, 50 steps of 20 cycles
	task automatic t_hd;
		int c0;
		bus(1'b1, 8'h18, 32'h328);
		bus(1'b1, 8'h00, 32'h11);
		repeat (100) @(posedge clk);
		i_ufir_line_model.send(8'h22);
		repeat (1100) @(posedge clk);
		rchk(8'h10, 32'h60);
		chk(32'(mb), 32'h11);
		i_ufir_line_model.send(8'h33);
		rchk(8'h00, 32'h33);
		c0 = mc;
		fork
			i_ufir_line_model.send(8'h44);
			begin
				repeat (300) @(posedge clk);
				bus(1'b1, 8'h00, 32'h55);
			end
		join
		repeat (800) @(posedge clk);
		rchk(8'h10, 32'h01);
		rchk(8'h00, 32'h44);
		wmc(c0 + 1);
		chk(32'(mb), 32'h55);
		bus(1'b1, 8'h18, 32'h0);
	endtask
	task automatic t_dd;
		logic [31:0] v[5] = '{32'h2000, 32'h4800, 32'h0800, 32'h1800, 32'h3000};
		logic [1:0] e[5] = '{2'h3, 2'h3, 2'h2, 2'h0, 2'h3};
		logic [31:0] q[5] = '{32'h2000, 32'h4800, 32'h0800, 32'h9800, 32'h3000};
		dd_ext <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, 8'h18, v[i]);
			repeat (4) @(posedge clk);
			chk({ddoe, ddout & ddoe}, e[i]);
			rchk(8'h18, q[i]);
		end
		dd_ext <= 1'b0;
		bus(1'b1, 8'h18, 32'h1800);
		repeat (4) @(posedge clk);
		rchk(8'h18, 32'h1800);
	endtask
	initial begin
		rst;
		t_reset;
		t_tx;
		t_burst;
		t_rx;
		t_tmo;
		t_hd;
		t_ir;
		t_dd;
		rst;
		t_reset;
		end_of_test;
	end
endmodule // ufir_top_tb
